// ---- hw/psfm_pkg.sv ----
// Purpose: Constants and types for the playback servo fault monitor
// Assumes: 100 MHz system clock
// Notes:   Register map is a plain port map of word indices
package psfm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int MISS_GAP_NS      = 750;
	localparam int MISS_GAP_CYC     = MISS_GAP_NS / CLK_PERIOD_NS;
	localparam int SYNC_ERR_MS      = 100;
	localparam int SYNC_ERR_CYC     = SYNC_ERR_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUF_DEPTH        = 2048;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_MASK   = 4'h2;
	localparam logic [3:0] REG_PHASE  = 4'h3;
	localparam logic [3:0] REG_FILL   = 4'h4;
	// Event bit positions in status and mask
	localparam int EV_STARVE   = 0;
	localparam int EV_OVERFLOW = 1;
	localparam int EV_MISSCLK  = 2;
	localparam int EV_SYNCERR  = 3;
	localparam int EV_RESET    = 4;
	localparam int EV_W        = 5;
	// Control bit positions
	localparam int CTL_HOLD    = 0;
	localparam int CTL_CLRFLT  = 1;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// ----------------------------------------
	// Servo phases
	// ----------------------------------------
	typedef enum logic [2:0] {
		idle_phase           = 3'b000,
		start_sequence_phase = 3'b001,
		resync_phase         = 3'b010,
		tracking_phase       = 3'b011,
		tracking_phase_late  = 3'b100,
		fault_phase          = 3'b101
	} psfm_phase_t;
endpackage

// ---- hw/psfm_sync2.sv ----
// Purpose: Two-stage synchroniser for a vector of pins
// Assumes: Inputs asynchronous to clock
// Notes:   First stage read only by the second
`timescale 1ns/1ns
module psfm_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	// Two flops; constant under reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// ---- hw/psfm_timer.sv ----
// Purpose: Retriggerable down counter; busy while counting
// Assumes: Same clock as user
// Notes:   A start during a count restarts it
`timescale 1ns/1ns
module psfm_timer #(
	parameter int N = 75
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      busy,
	output logic      expired
);
	logic [$clog2(N+1)-1:0] count;

	// Load on start, count down to zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count   <= '0;
			expired <= 1'b0;
		end else begin
			expired <= (count == 1) && !start;
			if (start) begin
				count <= ($clog2(N+1))'(N);
			end else if (count != 0) begin
				count <= count - 1'b1;
			end
		end
	end
	assign busy = (count != 0);
endmodule

// ---- hw/psfm_top.sv ----
// Purpose: Playback servo phase sequencer and data-stream fault monitor
// Assumes: Buttons, recovered clock/data, syncs and unload clock are async pins
// Notes:   Bit buffer is tracked as an occupancy count, not stored data
//
// What this block does
// - Stop halts remote recorders and forces the idle phase.
// - Start button sets start-sequence phase and runs remote recorders.
// - Buffer fault lights fault lamp; computer clears it soon after.
// - Reset-fault button returns to resync phase; computer returns to waiting.
// - Light missed-clock lamp after 750 ns with no clock edge.
// - Sync-error lamp for 0.1 s on two same-kind syncs in a row.
// - Flag starve when a bit loads after its unload pulse.
// - Flag overflow when over 2048 bits load before oldest unloads.
// - Starve or overflow outside idle jumps to fault phase unless hold is set.
// - Recorders start/stop together in remote.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
module psfm_top
	import psfm_pkg::*;
#(
	parameter int SYNC_ERR_CYCLES = SYNC_ERR_CYC,
	parameter int DEPTH           = BUF_DEPTH
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       stopButton,
	input  wire logic       start_sequence_button,
	input  wire logic       resetFaultButton,
	input  wire logic       remoteSelect,
	input  wire logic       loadClock,
	input  wire logic       unloadClock,
	input  wire logic       eofSync,
	input  wire logic       bofSync,
	input  wire logic       phaseAdvance,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	output logic            recorderRun,
	output logic      [2:0] servoPhase,
	output logic            faultLamp,
	output logic            missedClockLamp,
	output logic            syncErrorLamp,
	output logic            starveLamp,
	output logic            overflowLamp,
	output logic            irq
);
	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	localparam int NPIN = 9;
	logic [NPIN-1:0] pinS;
	logic            stopS, startS, resetS, remoteS, ldS, ulS, eofS, bofS, advS;

	psfm_sync2 #(.W(NPIN)) uSync (
		.clock (clock),
		.rst_n (rst_n),
		.din   ({stopButton, start_sequence_button, resetFaultButton, remoteSelect,
		         loadClock, unloadClock, eofSync, bofSync, phaseAdvance}),
		.dout  (pinS)
	);
	assign {stopS, startS, resetS, remoteS, ldS, ulS, eofS, bofS, advS} = pinS;

	// Rising-edge detection on synchronised pins only
	logic [NPIN-1:0] pinD;
	logic [NPIN-1:0] pinRise;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinD <= '0;
		end else begin
			pinD <= pinS;
		end
	end
	assign pinRise = pinS & ~pinD;
	logic stopP, startP, resetP, ldP, ulP, eofP, bofP, advP, ldEdge;
	assign stopP  = pinRise[8];
	assign startP = pinRise[7];
	assign resetP = pinRise[6];
	assign ldP    = pinRise[4];
	assign ulP    = pinRise[3];
	assign eofP   = pinRise[2];
	assign bofP   = pinRise[1];
	assign advP   = pinRise[0];
	assign ldEdge = pinS[4] ^ pinD[4]; // Any recovered-clock transition

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]     ctrl;
	logic [EV_W-1:0] status, mask, evt;
	logic           holdTrack;
	assign holdTrack = ctrl[CTL_HOLD];

	// Control register; clear-fault bit is self clearing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 8'h00;
		end else if (regWr && regAddr == REG_CTRL) begin
			ctrl <= regWrData;
		end else begin
			ctrl[CTL_CLRFLT] <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask <= MASK_RESET[EV_W-1:0];
		end else if (regWr && regAddr == REG_MASK) begin
			mask <= regWrData[EV_W-1:0];
		end
	end

	// Sticky status; a new event wins over the read clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
		end else if (regRd && regAddr == REG_STATUS) begin
			status <= evt;
		end else begin
			status <= status | evt;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// ----------------------------------------
	// Missed clock and sync error
	// ----------------------------------------
	logic gapExp, syncBusy, lastWasEof, haveSync, syncDup;

	// Gap timer restarts on every recovered clock edge
	psfm_timer #(.N(MISS_GAP_CYC)) uGap (
		.clock   (clock),
		.rst_n   (rst_n),
		.start   (ldEdge),
		.busy    (),
		.expired (gapExp)
	);

	// Lamp lit by a gap, cleared at the next transition
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			missedClockLamp <= 1'b0;
		end else if (gapExp) begin
			missedClockLamp <= 1'b1;
		end else if (ldEdge) begin
			missedClockLamp <= 1'b0;
		end
	end

	// Remember the kind of the last sync seen
	assign syncDup = haveSync && ((eofP && lastWasEof) || (bofP && !lastWasEof));
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			haveSync   <= 1'b0;
			lastWasEof <= 1'b0;
		end else if (eofP ^ bofP) begin
			haveSync   <= 1'b1;
			lastWasEof <= eofP;
		end
	end

	psfm_timer #(.N(SYNC_ERR_CYCLES)) uSyncErr (
		.clock   (clock),
		.rst_n   (rst_n),
		.start   (syncDup),
		.busy    (syncBusy),
		.expired ()
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncErrorLamp <= 1'b0;
		end else begin
			syncErrorLamp <= syncBusy;
		end
	end

	// ----------------------------------------
	// Bit buffer occupancy
	// ----------------------------------------
	// Signed count: negative means an unload ran ahead of its bit
	localparam int FW = $clog2(DEPTH) + 2;
	// Shift that leaves the top 8 bits; small depths read back sign extended
	localparam int FS = (FW > 8) ? FW - 8 : 0;
	logic signed [FW-1:0] fill, next_fill;
	logic                 starveEv, overflowEv;

	always_comb begin
		next_fill = fill;
		if (ldP && !ulP) begin
			next_fill = fill + FW'(1);
		end else if (ulP && !ldP) begin
			next_fill = fill - FW'(1);
		end
	end
	// Bit arriving while unloads are ahead of loads: it was missed
	assign starveEv   = ldP && !ulP && (fill < 0);
	assign overflowEv = ldP && !ulP && (fill >= FW'(DEPTH));

	// Count does not saturate; a fault or reset-fault resyncs the buffer to empty
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fill <= '0;
		end else if (resetP || starveEv || overflowEv) begin
			fill <= '0;
		end else begin
			fill <= next_fill;
		end
	end

	// Starve/overflow lamps held until reset-fault; fault lamp until reset-fault or computer clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			starveLamp   <= 1'b0;
			overflowLamp <= 1'b0;
			faultLamp    <= 1'b0;
		end else begin
			if (starveEv) begin
				starveLamp <= 1'b1;
			end else if (resetP) begin
				starveLamp <= 1'b0;
			end
			if (overflowEv) begin
				overflowLamp <= 1'b1;
			end else if (resetP) begin
				overflowLamp <= 1'b0;
			end
			// Set wins over the computer's clear
			if (starveEv || overflowEv) begin
				faultLamp <= 1'b1;
			end else if (ctrl[CTL_CLRFLT] || resetP) begin
				faultLamp <= 1'b0;
			end
		end
	end

	assign evt = {resetP, syncDup, gapExp, overflowEv, starveEv};

	// ----------------------------------------
	// Servo phase sequencer
	// ----------------------------------------
	psfm_phase_t phase, next_phase;

	// Buttons first, then faults, then normal advance
	always_comb begin
		next_phase = phase;
		case (phase)
			idle_phase:           next_phase = idle_phase;
			start_sequence_phase: if (advP) next_phase = resync_phase;
			resync_phase:         if (advP) next_phase = tracking_phase;
			tracking_phase:       if (advP) next_phase = tracking_phase_late;
			tracking_phase_late:  next_phase = tracking_phase_late;
			fault_phase:          next_phase = fault_phase;
			default:              next_phase = idle_phase;
		endcase
		if ((starveEv || overflowEv) && !holdTrack && phase != idle_phase) begin
			next_phase = fault_phase;
		end
		if (resetP) begin
			next_phase = resync_phase;
		end
		if (startP) begin
			next_phase = start_sequence_phase;
		end
		if (stopP) begin
			next_phase = idle_phase;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase <= idle_phase;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			servoPhase <= 3'b000;
		end else begin
			servoPhase <= next_phase;
		end
	end

	// Remote recorders run from start until stop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			recorderRun <= 1'b0;
		end else if (stopP) begin
			recorderRun <= 1'b0;
		end else if (startP && remoteS) begin
			recorderRun <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				REG_CTRL:   regRdData <= ctrl;
				REG_STATUS: regRdData <= 8'(status);
				REG_MASK:   regRdData <= 8'(mask);
				REG_PHASE:  regRdData <= 8'(phase);
				REG_FILL:   regRdData <= 8'(fill >>> FS);
				default:    regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_stop;
		stopP;
	endsequence

	a_stop_idle: assert property (@(posedge clock) disable iff (!rst_n)
		s_stop |=> (phase == idle_phase) && !recorderRun)
		else $error("stop did not reach idle");
	a_start_seq: assert property (@(posedge clock) disable iff (!rst_n)
		startP && !stopP |=> phase == start_sequence_phase)
		else $error("start did not set sequence phase");
	a_reset_resync: assert property (@(posedge clock) disable iff (!rst_n)
		resetP && !startP && !stopP |=> phase == resync_phase)
		else $error("reset did not resync");
	a_fault_lamp: assert property (@(posedge clock) disable iff (!rst_n)
		(starveEv || overflowEv) |=> faultLamp)
		else $error("fault lamp not lit");
	a_gap_lamp: assert property (@(posedge clock) disable iff (!rst_n)
		gapExp |=> missedClockLamp)
		else $error("missed clock lamp not lit");
	a_sync_err: assert property (@(posedge clock) disable iff (!rst_n)
		syncDup |=> ##1 syncErrorLamp [*8])
		else $error("sync error lamp too short");
	a_fault_jump: assert property (@(posedge clock) disable iff (!rst_n)
		(starveEv || overflowEv) && !holdTrack && !resetP && !startP && !stopP
		&& phase != idle_phase |=> phase == fault_phase)
		else $error("fault phase not entered");
	a_overflow_lvl: assert property (@(posedge clock) disable iff (!rst_n)
		overflowEv |-> fill == FW'(DEPTH))
		else $error("overflow at wrong level");
endmodule

// ---- tb/psfm_recorder_model.sv ----
// Purpose: Behavioural pair of playback recorders feeding the monitor
// Assumes: Recovered clock period 160 ns, unrelated to the system clock
// Notes:   Clock stands still between bursts, like a tape between frames
`timescale 1ns/1ns
module psfm_recorder_model (
	input  wire logic run,
	output logic      loadClock,
	output logic      eofSync,
	output logic      bofSync
);
	// --------------------------------
	// Idle levels
	// --------------------------------
	initial begin
		loadClock = 1'b0;
		eofSync   = 1'b0;
		bofSync   = 1'b0;
	end

	// Recovered clock, only while the controller runs us
	task automatic burst(input int n);
		#3;
		for (int i = 0; i < n; i++) begin
			if (run) begin
				loadClock = 1'b1;
				#80;
				loadClock = 1'b0;
				#80;
			end
		end
	endtask

	// Frame sync pulse, long enough to survive the synchroniser
	task automatic frameSync(input bit isBof);
		if (isBof)
			bofSync = 1'b1;
		else
			eofSync = 1'b1;
		#60;
		eofSync = 1'b0;
		bofSync = 1'b0;
		#200;
	endtask
endmodule

// ---- tb/psfm_top_tb.sv ----
// Purpose: Self-checking bench for the servo fault monitor
// Assumes: Sync-error hold shortened to 50 cycles, buffer depth to 8
// Notes:   Pin effects checked a fixed settle time after each edge
`timescale 1ns/1ns
module psfm_top_tb;
	import psfm_pkg::*;
	localparam int SEC = 50;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic [3:0] btn   = 4'h0;
	logic       remoteSelect = 1'b1;
	logic       unloadClock  = 1'b0;
	logic [3:0] regAddr   = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWr = 1'b0;
	logic       regRd = 1'b0;
	logic [7:0] regRdData;
	logic       recorderRun, faultLamp, missedClockLamp, syncErrorLamp;
	logic       starveLamp, overflowLamp, irq, loadClock, eofSync, bofSync;
	logic [2:0] servoPhase;
	int         miscompares = 0;
	int         checked = 0;
	logic [7:0] rdv;

	always #5 clock = ~clock;

	psfm_recorder_model rec_u (.run(recorderRun), .loadClock(loadClock),
		.eofSync(eofSync), .bofSync(bofSync));

	psfm_top #(.SYNC_ERR_CYCLES(SEC), .DEPTH(8)) dut_u (
		.clock(clock), .rst_n(rst_n), .stopButton(btn[0]),
		.start_sequence_button(btn[1]), .resetFaultButton(btn[2]),
		.remoteSelect(remoteSelect), .loadClock(loadClock),
		.unloadClock(unloadClock), .eofSync(eofSync), .bofSync(bofSync),
		.phaseAdvance(btn[3]), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.recorderRun(recorderRun), .servoPhase(servoPhase),
		.faultLamp(faultLamp), .missedClockLamp(missedClockLamp),
		.syncErrorLamp(syncErrorLamp), .starveLamp(starveLamp),
		.overflowLamp(overflowLamp), .irq(irq));

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Button held 4 cycles, then time for the synchroniser to settle
	task automatic press(input int i);
		@(posedge clock) btn <= 4'h1 << i;
		repeat (4) @(posedge clock);
		btn <= 4'h0;
		repeat (6) @(posedge clock);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock) begin
			regWr <= 1'b1;
			regAddr <= a;
			regWrData <= d;
		end
		@(posedge clock) regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock) begin
			regRd <= 1'b1;
			regAddr <= a;
		end
		@(posedge clock) regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	task automatic unload(input int n);
		repeat (n) begin
			@(posedge clock) unloadClock <= 1'b1;
			repeat (8) @(posedge clock);
			unloadClock <= 1'b0;
			repeat (8) @(posedge clock);
		end
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic tReset();
		chk({5'h0, servoPhase}, 8'h00);
		chk({recorderRun, faultLamp, starveLamp, overflowLamp, irq}, 8'h00);
		rd(REG_MASK, rdv);
		chk(rdv, MASK_RESET);
		rd(4'hf, rdv);
		chk(rdv, 8'h00); // unmapped read
	endtask

	task automatic tStart();
		press(1);
		chk({5'h0, servoPhase}, 8'h01);
		chk({7'h0, recorderRun}, 8'h01);
	endtask

	task automatic tMissedClock();
		rec_u.burst(3);
		repeat (20) @(posedge clock);
		chk({7'h0, missedClockLamp}, 8'h00);
		repeat (80) @(posedge clock);
		chk({7'h0, missedClockLamp}, 8'h01);
		rec_u.burst(1);
		repeat (6) @(posedge clock);
		chk({7'h0, missedClockLamp}, 8'h00);
	endtask

	// Four bits held; five more with nothing unloaded overruns depth 8
	task automatic tOverflowHold();
		wr(REG_CTRL, 8'h01);
		rd(REG_CTRL, rdv);
		chk(rdv, 8'h01);
		wr(REG_MASK, 8'h02);
		rec_u.burst(5);
		repeat (8) @(posedge clock);
		chk({7'h0, overflowLamp}, 8'h01);
		chk({5'h0, servoPhase}, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(REG_STATUS, rdv);
		chk(rdv & 8'h02, 8'h02);
		repeat (3) @(posedge clock);
		chk({7'h0, irq}, 8'h00);
	endtask

	task automatic tStarve();
		wr(REG_CTRL, 8'h00);
		unload(1);
		rd(REG_FILL, rdv);
		chk(rdv, 8'hff);
		rec_u.burst(1);
		repeat (8) @(posedge clock);
		chk({7'h0, starveLamp}, 8'h01);
		chk({5'h0, servoPhase}, 8'h05);
		chk({7'h0, faultLamp}, 8'h01);
		wr(REG_CTRL, 8'h02);
		repeat (2) @(posedge clock);
		chk({7'h0, faultLamp}, 8'h00);
	endtask

	// Reset-fault button's answer to a fault phase, then the walk to late tracking
	task automatic tResetFault();
		press(2);
		chk({5'h0, servoPhase}, 8'h02);
		press(3);
		chk({5'h0, servoPhase}, 8'h03);
		press(3);
		chk({5'h0, servoPhase}, 8'h04);
		rd(REG_PHASE, rdv);
		chk(rdv, 8'h04);
	endtask

	task automatic tSyncError();
		rec_u.frameSync(1'b0);
		rec_u.frameSync(1'b0);
		repeat (8) @(posedge clock);
		chk({7'h0, syncErrorLamp}, 8'h01);
		repeat (SEC + 10) @(posedge clock);
		chk({7'h0, syncErrorLamp}, 8'h00);
		rec_u.frameSync(1'b1);
		rec_u.frameSync(1'b0);
		repeat (8) @(posedge clock);
		chk({7'h0, syncErrorLamp}, 8'h00);
	endtask

	task automatic tStop();
		press(0);
		chk({5'h0, servoPhase}, 8'h00);
		chk({7'h0, recorderRun}, 8'h00);
	endtask

	// Local control: start sets the phase but leaves the recorders alone
	task automatic tLocal();
		@(posedge clock) remoteSelect <= 1'b0;
		press(1);
		chk({5'h0, servoPhase}, 8'h01);
		chk({7'h0, recorderRun}, 8'h00);
		@(posedge clock) remoteSelect <= 1'b1;
	endtask

	// --------------------------------
	// Main sequence and watchdog
	// --------------------------------
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		tReset();
		tStart();
		tMissedClock();
		tOverflowHold();
		tStarve();
		tResetFault();
		tSyncError();
		tStop();
		tLocal();
		results();
	end

	// Cuts a hang short well inside the cycle budget
	initial begin
		#500000;
		miscompares++;
		results();
	end
endmodule
